// File: bus_clock_divider.sv
`timescale 1ns/1ps
module bus_clock_divider
  import i2c_ctrl_pkg::*;
#(
  parameter int CNT_WIDTH = 8
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [1:0] sel,
  output logic            tick
);
  if (CNT_WIDTH < 7) begin : g_width_check
    $error("bus_clock_divider: CNT_WIDTH too small");
  end

  logic [CNT_WIDTH-1:0] count;
  wire  [CNT_WIDTH-1:0] limit = CNT_WIDTH'(quarter_count(sel));
  wire                  wrap  = (count >= limit - CNT_WIDTH'(1));

  // Quarter bit tick; four ticks make one serial clock period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= wrap ? '0 : count + CNT_WIDTH'(1);
      tick  <= wrap;
    end
  end

  a_slowest_ratio : assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && sel == 2'h3 && $stable(sel)) |=> !tick [*8])
    else $error("tick too early at divide by 256");
endmodule // bus_clock_divider

// File: i2c_ctrl_pkg.sv
package i2c_ctrl_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CTRL_OFFSET       = 8'h00;
  localparam logic [7:0] DATA_OFFSET       = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFFSET   = 8'h0C;
  localparam logic [7:0] PIN_CODE_OFFSET   = 8'h10;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int ENABLE_BIT  = 7;
  localparam int ACK_OUT_BIT = 6;
  localparam int DONE_BIT    = 5;
  localparam int ACK_IN_BIT  = 4;
  localparam int START_BIT   = 3;
  localparam int STOP_BIT    = 2;
  localparam int DIV_LSB     = 0;

  localparam logic [7:0] CTRL_RESET     = 8'h04;
  localparam logic [3:0] PIN_CODE_RESET = 4'h1;
  localparam logic [3:0] PIN_OPEN_DRAIN = 4'h0;
  localparam logic [1:0] PIN_PUSH_PULL  = 2'h2;

  // ****************************************
  // Interrupt status and mask fields
  // ****************************************
  localparam int IRQ_BYTE_BIT = 0;
  localparam int IRQ_STOP_BIT = 1;
  localparam int IRQ_BITS     = 2;

  // ****************************************
  // Quarter bit periods for ratios 4, 16, 64, 256
  // ****************************************
  localparam logic [7:0] QUARTER_DIV4   = 8'h01;
  localparam logic [7:0] QUARTER_DIV16  = 8'h04;
  localparam logic [7:0] QUARTER_DIV64  = 8'h10;
  localparam logic [7:0] QUARTER_DIV256 = 8'h40;

  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_BITS  = 3'b010,
    ST_WAIT  = 3'b011,
    ST_STOP  = 3'b100
  } engine_state_type;

  function automatic logic [7:0] quarter_count(input logic [1:0] sel);
    case (sel)
      2'h0:    quarter_count = QUARTER_DIV4;
      2'h1:    quarter_count = QUARTER_DIV16;
      2'h2:    quarter_count = QUARTER_DIV64;
      default: quarter_count = QUARTER_DIV256;
    endcase
  endfunction

endpackage

// File: i2c_master_byte_controller.sv
`timescale 1ns/1ps
// What this block does
// - After START send seven address bits, direction
// - Byte-done flag set after address byte
// - Data write sends byte, flag set again
// - Dummy data read starts first reception
// - Received byte sets flag; read starts next
// - Flag set raises interrupt when enabled
// - Pin code 0000: open-drain serial clock
// - Acknowledge out: zero ACK, one NACK
// - Data write between START, STOP resumes sending
module i2c_master_byte_controller
  import i2c_ctrl_pkg::*;
#(
  parameter int ADDR_BITS = 8
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [ADDR_BITS-1:0] haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  wire logic                 scl_i,
  output logic                      scl_o,
  output logic                      scl_oe,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe,
  output logic                      irq
);
  if (ADDR_BITS < 5) begin : g_addr_check
    $error("i2c_master_byte_controller: ADDR_BITS too small");
  end

  // ****************************************
  // State
  // ****************************************
  logic                  controller_enable;
  logic                  ack_out_select;
  logic                  byte_done_flag;
  logic                  ack_in_status;
  logic                  start_request;
  logic                  stop_request;
  logic [1:0]            bus_clock_divider_select;
  logic [7:0]            bus_shift_data;
  logic [IRQ_BITS-1:0]   irq_status;
  logic [IRQ_BITS-1:0]   irq_mask;
  logic [3:0]            pin_function_code;
  logic                  wr_pending;
  logic [7:0]            wr_addr;
  logic                  cmd_tx;
  logic                  cmd_rx;
  logic                  start_armed;
  engine_state_type      state;
  logic [1:0]            phase;
  logic [3:0]            bit_cnt;
  logic                  is_tx;
  logic                  scl_level;
  logic                  sda_level;
  logic                  scl_in;
  logic                  sda_in;
  logic                  tick;

  // ****************************************
  // Pins and divider
  // ****************************************
  pin_sync u_scl_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     (scl_i),
    .level   (scl_in)
  );

  pin_sync u_sda_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     (sda_i),
    .level   (sda_in)
  );

  bus_clock_divider #(
    .CNT_WIDTH (8)
  ) u_divider (
    .hclk    (hclk),
    .hresetn (hresetn),
    .sel     (bus_clock_divider_select),
    .tick    (tick)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  wire [7:0] addr8      = 8'(haddr);
  wire       accept     = hsel && htrans[1] && hready && (hsize == HSIZE_WORD);
  wire       rd_accept  = accept && !hwrite;
  wire       rd_data    = rd_accept && (addr8 == DATA_OFFSET);
  wire       rd_status  = rd_accept && (addr8 == IRQ_STATUS_OFFSET);
  wire       wr_ctrl    = wr_pending && (wr_addr == CTRL_OFFSET);
  wire       wr_data    = wr_pending && (wr_addr == DATA_OFFSET);
  wire       wr_mask    = wr_pending && (wr_addr == IRQ_MASK_OFFSET);
  wire       wr_pin     = wr_pending && (wr_addr == PIN_CODE_OFFSET);
  wire       in_frame   = (state != ST_IDLE);
  wire [7:0] ctrl_value = {controller_enable, ack_out_select, byte_done_flag, ack_in_status,
                           start_request, stop_request, bus_clock_divider_select};
  wire [31:0] read_value;

  assign read_value = (addr8 == CTRL_OFFSET)       ? {24'h0, ctrl_value} :
                      (addr8 == DATA_OFFSET)       ? {24'h0, bus_shift_data} :
                      (addr8 == IRQ_STATUS_OFFSET) ? {30'h0, irq_status} :
                      (addr8 == IRQ_MASK_OFFSET)   ? {30'h0, irq_mask} :
                      (addr8 == PIN_CODE_OFFSET)   ? {28'h0, pin_function_code} : 32'h0;

  // ****************************************
  // Engine decode
  // ****************************************
  // Stretch seen late in high phase, after sync lag; none at divide by 4
  wire stretch    = (state == ST_BITS || state == ST_STOP) && phase == 2'h3 && !scl_in &&
                    (bus_clock_divider_select != 2'h0);
  wire adv        = tick && !stretch;
  wire ack_slot   = (bit_cnt == 4'h8);
  wire byte_event = adv && state == ST_BITS && phase == 2'h3 && ack_slot;
  wire stop_event = adv && state == ST_STOP && phase == 2'h3;
  wire go         = controller_enable && start_request && !stop_request && start_armed;
  wire last_nack  = !is_tx && ack_out_select && stop_request;
  wire wait_stop  = stop_request && !start_request && !cmd_tx && !cmd_rx;
  wire [IRQ_BITS-1:0] irq_events = {stop_event, byte_event};
  wire pin_od     = (pin_function_code == PIN_OPEN_DRAIN);
  wire pin_pp     = (pin_function_code[1:0] == PIN_PUSH_PULL);

  // ****************************************
  // AHB-Lite slave, zero wait states
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_addr    <= 8'h00;
      hrdata     <= 32'h0;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      wr_pending <= accept && hwrite;
      wr_addr    <= addr8;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      if (rd_accept) begin
        hrdata <= read_value;
      end
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      controller_enable        <= CTRL_RESET[ENABLE_BIT];
      ack_out_select           <= CTRL_RESET[ACK_OUT_BIT];
      start_request            <= CTRL_RESET[START_BIT];
      stop_request             <= CTRL_RESET[STOP_BIT];
      bus_clock_divider_select <= CTRL_RESET[DIV_LSB+1:DIV_LSB];
      irq_mask                 <= '0;
      pin_function_code        <= PIN_CODE_RESET;
    end else begin
      if (wr_ctrl) begin
        controller_enable        <= hwdata[ENABLE_BIT];
        ack_out_select           <= hwdata[ACK_OUT_BIT];
        start_request            <= hwdata[START_BIT];
        stop_request             <= hwdata[STOP_BIT];
        bus_clock_divider_select <= hwdata[DIV_LSB+1:DIV_LSB];
      end
      if (wr_mask) begin
        irq_mask <= hwdata[IRQ_BITS-1:0];
      end
      if (wr_pin) begin
        pin_function_code <= hwdata[3:0];
      end
    end
  end

  // Write 0 clears; a byte finishing in the same cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      byte_done_flag <= CTRL_RESET[DONE_BIT];
    end else if (byte_event) begin
      byte_done_flag <= 1'b1;
    end else if (wr_ctrl && !hwdata[DONE_BIT]) begin
      byte_done_flag <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt status, read clears
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= '0;
      irq        <= 1'b0;
    end else begin
      irq_status <= irq_events | (rd_status ? '0 : irq_status);
      irq        <= |(irq_status & irq_mask);
    end
  end

  // ****************************************
  // Software commands
  // ****************************************
  // Outside a frame a data read has no effect on the bus
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_tx      <= 1'b0;
      cmd_rx      <= 1'b0;
      start_armed <= 1'b0;
    end else begin
      if (state == ST_WAIT && adv) begin
        cmd_tx <= 1'b0;
        cmd_rx <= 1'b0;
      end
      if (wr_data && in_frame) cmd_tx <= 1'b1;
      if (rd_data && in_frame) cmd_rx <= 1'b1;
      if (state == ST_IDLE && !start_request) begin
        start_armed <= 1'b1;
      end else if (state == ST_IDLE && adv && go) begin
        start_armed <= 1'b0;
      end
    end
  end

  // Data register doubles as the bus shift register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_shift_data <= 8'h00;
    end else if (wr_data) begin
      bus_shift_data <= hwdata[7:0];
    end else if (adv && state == ST_BITS && phase == 2'h2 && !ack_slot) begin
      bus_shift_data <= {bus_shift_data[6:0], sda_in};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_in_status <= CTRL_RESET[ACK_IN_BIT];
    end else if (adv && state == ST_BITS && phase == 2'h2 && ack_slot && is_tx) begin
      ack_in_status <= sda_in;
    end
  end

  // ****************************************
  // Byte engine, one step per quarter bit
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= ST_IDLE;
      phase     <= 2'h0;
      bit_cnt   <= 4'h0;
      is_tx     <= 1'b1;
      scl_level <= 1'b1;
      sda_level <= 1'b1;
    end else if (adv) begin
      phase <= phase + 2'h1;
      case (state)
        ST_IDLE: begin
          phase     <= 2'h0;
          scl_level <= 1'b1;
          sda_level <= 1'b1;
          if (go) state <= ST_START;
        end
        ST_START: begin
          if (phase == 2'h1) sda_level <= 1'b0;
          if (phase == 2'h2) scl_level <= 1'b0;
          if (phase == 2'h3) begin
            state   <= ST_BITS;
            bit_cnt <= 4'h0;
            is_tx   <= 1'b1;
          end
        end
        ST_BITS: begin
          case (phase)
            2'h0: begin
              scl_level <= 1'b0;
              if (ack_slot) sda_level <= is_tx ? 1'b1 : ack_out_select;
              else          sda_level <= is_tx ? bus_shift_data[7] : 1'b1;
            end
            2'h1:    scl_level <= 1'b1;
            2'h2:    scl_level <= 1'b1;
            default: begin
              scl_level <= 1'b0;
              bit_cnt   <= bit_cnt + 4'h1;
              if (ack_slot) state <= last_nack ? ST_STOP : ST_WAIT;
            end
          endcase
        end
        ST_WAIT: begin
          phase <= 2'h0;
          if (cmd_tx || cmd_rx) begin
            state   <= ST_BITS;
            bit_cnt <= 4'h0;
            is_tx   <= cmd_tx;
          end else if (wait_stop) begin
            state <= ST_STOP;
          end else if (!controller_enable) begin
            state <= ST_IDLE;
          end
        end
        ST_STOP: begin
          if (phase == 2'h0) begin
            scl_level <= 1'b0;
            sda_level <= 1'b0;
          end
          if (phase == 2'h1) scl_level <= 1'b1;
          if (phase == 2'h2) sda_level <= 1'b1;
          if (phase == 2'h3) state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  // Open drain only ever pulls low; the pull-up makes the high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_o  <= 1'b0;
      scl_oe <= 1'b0;
      sda_o  <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_o  <= pin_pp && scl_level;
      scl_oe <= pin_od ? !scl_level : pin_pp;
      sda_o  <= 1'b0;
      sda_oe <= !sda_level;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_address_first : assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_START && phase == 2'h3 && adv) |=> (state == ST_BITS && is_tx && bit_cnt == 4'h0))
    else $error("address byte not started after START");

  a_flag_on_byte : assert property (@(posedge hclk) disable iff (!hresetn)
    byte_event |=> byte_done_flag)
    else $error("byte-done flag not set");

  a_write_resumes : assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_WAIT && adv && cmd_tx) |=> (state == ST_BITS && is_tx))
    else $error("data write did not resume transmit");

  a_read_starts : assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_WAIT && rd_data && !cmd_tx) |-> ##[1:80] (state == ST_BITS && !is_tx))
    else $error("data read did not start reception");

  a_irq_raised : assert property (@(posedge hclk) disable iff (!hresetn)
    (byte_event && irq_mask[IRQ_BYTE_BIT] && !wr_mask) |-> ##2 irq)
    else $error("enabled byte interrupt missing");

  a_ack_driven : assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_BITS && ack_slot && !is_tx && phase == 2'h1 && $past(adv)) |->
    (sda_level == $past(ack_out_select)))
    else $error("wrong acknowledge driven");

  a_ack_captured : assert property (@(posedge hclk) disable iff (!hresetn)
    (adv && state == ST_BITS && ack_slot && is_tx && phase == 2'h2) |=> (ack_in_status == $past(sda_in)))
    else $error("slave acknowledge not captured");

  a_stop_issued : assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_WAIT && adv && wait_stop) |=> state == ST_STOP ##[1:300] state == ST_IDLE)
    else $error("STOP not issued");

  a_nack_then_stop : assert property (@(posedge hclk) disable iff (!hresetn)
    (byte_event && last_nack) |=> state == ST_STOP)
    else $error("no STOP after final NACK");

  a_open_drain : assert property (@(posedge hclk) disable iff (!hresetn)
    ($past(pin_od) && $past(hresetn)) |-> (!scl_o && scl_oe == !$past(scl_level)))
    else $error("serial clock not open drain");

  c_tx_byte : cover property (@(posedge hclk) disable iff (!hresetn) byte_event && is_tx);
  c_rx_byte : cover property (@(posedge hclk) disable iff (!hresetn) byte_event && !is_tx);
  c_stop    : cover property (@(posedge hclk) disable iff (!hresetn) stop_event);
  c_irq     : cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
endmodule // i2c_master_byte_controller

// File: i2c_slave_model.sv
`timescale 1ns/1ps
// ********
// Bus slave
// ********
module i2c_slave_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] rd_first,
  input  wire logic [7:0] rd_next,
  output logic            sda_oe,
  output logic [7:0]      last_rx,
  output logic            master_nack,
  output logic            stop_seen
);
  logic [7:0] sh;
  logic       rd;
  int         k;
  initial begin
    sda_oe = 1'b0;
    last_rx = 8'h00;
    master_nack = 1'b0;
    stop_seen = 1'b0;
    rd = 1'b0;
  end
  always @(negedge sda) if (scl === 1'b1) begin : frame
    stop_seen = 1'b0;
    k = 0;
    forever begin
      if (k > 0 && rd) begin
        sh = (k == 1) ? rd_first : rd_next;
        repeat (8) begin
          sda_oe = !sh[7];
          sh = {sh[6:0], 1'b0};
          @(negedge scl);
        end
        // Release for the master acknowledge
        sda_oe = 1'b0;
        @(posedge scl);
        master_nack = sda;
        @(negedge scl);
      end else begin
        repeat (8) begin
          @(posedge scl);
          sh = {sh[6:0], sda};
        end
        @(negedge scl);
        last_rx = sh;
        if (k == 0) rd = sh[0];
        sda_oe = (k > 0) || (sh[7:1] == DEV_ADDR);
        @(negedge scl);
        sda_oe = 1'b0;
      end
      k++;
    end
  end
  // STOP aborts whatever byte was pending
  always @(posedge sda) if (scl === 1'b1) begin
    disable frame;
    sda_oe = 1'b0;
    stop_seen = 1'b1;
  end
endmodule // i2c_slave_model

// File: pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pin,
  output logic      level
);
  logic [2:0] stage;

  // Change accepted once the last two stages agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage <= 3'h7;
      level <= 1'b1;
    end else begin
      stage <= {stage[1:0], pin};
      if (stage[1] == stage[2]) begin
        level <= stage[2];
      end
    end
  end
endmodule // pin_sync

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  import i2c_ctrl_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, irq;
  logic [31:0] hrdata, d;
  logic        s_oe, m_nack, stop_seen;
  logic [7:0]  last_rx;
  logic [7:0]  rd_first = 8'h25;
  logic [7:0]  rd_next = 8'hA6;
  wire         hready = hreadyout;
  wire         scl_line = !(scl_oe && !scl_o);
  wire         sda_line = !(sda_oe || s_oe);
  int          error_cnt = 0;
  int          checks = 0;
  int          cyc = 0;
  int          last_rise = 0;
  int          scl_per = 0;
  logic        scl_q = 1'b1;
  always #5 hclk = ~hclk;
  i2c_master_byte_controller DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
  i2c_slave_model slave (.scl(scl_line), .sda(sda_line), .rd_first(rd_first),
    .rd_next(rd_next), .sda_oe(s_oe), .last_rx(last_rx), .master_nack(m_nack),
    .stop_seen(stop_seen));
  // ********
  // Helpers
  // ********
  // Cycles between SCL rises; a hung run ends here
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    scl_q <= scl_line;
    if (scl_line && !scl_q) begin
      scl_per <= cyc - last_rise;
      last_rise <= cyc;
    end
    if (cyc == 40000) begin
      error_cnt++;
      test_done;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask
  task automatic wait_ready;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
  endtask
  task automatic bus_phase(input logic [7:0] a, input logic w);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    hsize  <= HSIZE_WORD;
    wait_ready;
    hsel   <= 1'b0;
    htrans <= 2'h0;
  endtask
  task automatic ahb_write(input logic [7:0] a, input logic [31:0] v);
    bus_phase(a, 1'b1);
    hwdata <= v;
    wait_ready;
  endtask
  task automatic ahb_read(input logic [7:0] a);
    bus_phase(a, 1'b0);
    wait_ready;
    d = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string m);
    ahb_read(a);
    check(d, exp, m);
  endtask
  // Bounded wait on irq (0) or bus STOP (1)
  task automatic wait_sig(input bit stop);
    int n;
    n = 0;
    while (((stop ? stop_seen : irq) !== 1'b1) && n < 20000) begin
      @(posedge hclk);
      n++;
    end
    check(n < 20000, 1'b1, "wait timeout");
  endtask
  task automatic ctrl(input logic [7:0] v);
    ahb_write(CTRL_OFFSET, {24'h0, v});
  endtask
  task automatic tx_frame(input logic [1:0] sel);
    ahb_write(DATA_OFFSET, {24'h0, 7'h2A, 1'b0});
    ctrl(8'h88 | {6'h0, sel});
    wait_sig(0);
    check(scl_per, 32'h4 << (2 * sel), "scl bit period");
    check(last_rx, {7'h2A, 1'b0}, "address byte");
    rd_chk(CTRL_OFFSET, {24'h0, 8'hA8 | {6'h0, sel}}, "done, ack in");
    rd_chk(IRQ_STATUS_OFFSET, 32'h1, "byte status");
    @(posedge hclk);
    check(irq, 1'b0, "irq cleared");
    ctrl(8'h88 | {6'h0, sel});
    ahb_write(DATA_OFFSET, 32'hA5);
    wait_sig(0);
    check(last_rx, 8'hA5, "data byte");
    rd_chk(IRQ_STATUS_OFFSET, 32'h1, "byte status");
    ctrl(8'h84 | {6'h0, sel});
    wait_sig(1);
    repeat (8 << (2 * sel)) @(posedge hclk);
    check(irq, 1'b0, "masked stop");
    rd_chk(IRQ_STATUS_OFFSET, 32'h2, "stop status");
    ctrl(8'h80 | {6'h0, sel});
    repeat (8 << (2 * sel)) @(posedge hclk);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ********
  // Tests
  // ********
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(CTRL_OFFSET, {24'h0, CTRL_RESET}, "ctrl reset");
    rd_chk(PIN_CODE_OFFSET, {28'h0, PIN_CODE_RESET}, "pin reset");
    rd_chk(IRQ_MASK_OFFSET, 32'h0, "mask reset");
    rd_chk(8'h20, 32'h0, "unmapped");
    check(scl_oe, 1'b0, "scl released");
    check({hresp, sda_o}, 2'b00, "okay, sda low");
    ahb_write(PIN_CODE_OFFSET, {30'h0, PIN_PUSH_PULL});
    repeat (2) @(posedge hclk);
    check({scl_oe, scl_o}, 2'b11, "push-pull idle high");
    $display("test reset done");
    ahb_write(PIN_CODE_OFFSET, {28'h0, PIN_OPEN_DRAIN});
    ahb_write(IRQ_MASK_OFFSET, 32'h1);
    ctrl(8'h80);
    check(scl_oe, 1'b0, "open drain idle");
    for (int s = 0; s < 4; s++) tx_frame(s[1:0]);
    $display("test transmit done");
    // Receive at divide by 16: pin sync lag is too long for divide by 4
    ahb_write(DATA_OFFSET, {24'h0, 7'h2A, 1'b1});
    ctrl(8'h89);
    wait_sig(0);
    rd_chk(IRQ_STATUS_OFFSET, 32'h1, "addr status");
    ctrl(8'h89);
    ahb_read(DATA_OFFSET);
    wait_sig(0);
    rd_chk(IRQ_STATUS_OFFSET, 32'h1, "rx status");
    check(m_nack, 1'b0, "ack out zero");
    ctrl(8'hCD);
    rd_chk(DATA_OFFSET, 32'h25, "first rx byte");
    wait_sig(0);
    wait_sig(1);
    check(m_nack, 1'b1, "nack on last");
    rd_chk(DATA_OFFSET, 32'hA6, "last rx byte");
    $display("test receive done");
    test_done;
  end
endmodule // testbench
